// ### bench/signal_output_function_select_tb.sv
`timescale 1ns/1ns
module signal_output_function_select_tb;
  logic i_clk, i_srst, wr, rd, run, cfg, stage, ack, err;
  logic [15:0] addr, wd, rdata, r, c;
  logic [2:0] dout, e;
  logic [47:0] act, act_exp, nxt;
  int n_fail, compares, seed;
  localparam logic [15:0] FN [11] = '{16'h0001, 16'h0002, 16'h0003, 16'h0005, 16'h0006,
    16'h0007, 16'h0008, 16'h0009, 16'h000D, 16'h000E, 16'h0010};
  localparam logic [15:0] BAD [6] = '{16'h0000, 16'h0004, 16'h000A, 16'h000B, 16'h000F,
    16'h0011};
  sofs_top dut (.i_clk(i_clk), .i_srst(i_srst), .i_wr(wr), .i_rd(rd), .i_addr(addr),
    .i_wdata(wd), .o_rdata(rdata), .o_ack(ack), .o_err(err), .i_power_stage_en(stage),
    .i_drive_state(r[2:0]), .i_mode(r[4:3]), .i_pos_win(r[5]), .i_vel_win(r[6]),
    .i_vel_below(r[7]), .i_cur_below(r[8]), .i_halt_ack(r[9]), .i_standstill(r[10]),
    .i_sel_err(r[11]), .i_sel_warn(r[12]), .i_user_level(r[15:13]), .o_dout(dout),
    .o_active_sel(act));
  sofs_ctrl_model ctrl (.i_run(run), .i_cfg(cfg), .o_stage_en(stage));
  function automatic logic fx(input logic [15:0] s, input logic [15:0] v, input int k);
    case (s)
      16'h0001: fx = v[13+k];
      16'h0002: fx = v[2:0] inside {3'h2, 3'h3, 3'h4};
      16'h0003: fx = v[2:0] == 3'h4;
      16'h0005: fx = v[5] && v[4:3] < 2'h2;
      16'h0006: fx = v[6] && v[4:3] != 2'h2;
      16'h0007, 16'h0008, 16'h0009: fx = v[s[3:0]];
      16'h000D, 16'h000E: fx = v[s[3:0]-3];
      16'h0010: fx = v[12];
      default: fx = 1'b0;
    endcase
  endfunction
  task automatic chk(input string n, input logic [47:0] s, input logic [47:0] x);
    compares++;
    if (s !== x) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d, input logic b);
    @(posedge i_clk);
    {wr, rd, addr, wd} <= {w, !w, a, d};
    @(posedge i_clk);
    {wr, rd} <= 2'h0;
    #1;
    chk("err", err, b);
    chk("ack", ack, !b);
  endtask
  task automatic summarize();
    if (n_fail == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    i_clk = 0;
    forever #2 i_clk = ~i_clk;
  end
  initial begin
    repeat (4000) @(posedge i_clk);
    n_fail++;
    summarize();
  end
  initial begin
    {i_srst, wr, rd, run, cfg, addr, wd, r} = {1'b1, 52'h0};
    {seed, n_fail, compares} = {32'hbe1b, 64'h0};
    act_exp = {3{16'h0001}};
    nxt = act_exp;
    repeat (12) @(posedge i_clk);
    i_srst <= 0;
    for (int k = 0; k < 3; k++) begin
      acc(0, 16'h0712 + 16'(2 * k), 16'h0000, 0);
      chk("reset_sel", rdata, 16'h0001);
    end
    @(posedge i_clk) run <= 1;
    acc(1, 16'h0712, 16'h0003, 1);
    acc(0, 16'h0712, 16'h0000, 0);
    @(posedge i_clk) cfg <= 1;
    acc(1, 16'h0718, 16'h0001, 1);
    foreach (BAD[i]) acc(1, 16'h0714, BAD[i], 1);
    acc(0, 16'h0714, 16'h0000, 0);
    chk("kept", rdata, 16'h0001);
    for (int g = 0; g < 4; g++) begin
      for (int k = 0; k < 3; k++) begin
        c = FN[(3 * g + k) % 11];
        nxt[16*k +: 16] = c;
        acc(1, 16'h0712 + 16'(2 * k), c, 0);
        acc(0, 16'h0712 + 16'(2 * k), 16'h0000, 0);
        chk("stored", rdata, c);
      end
      chk("active", act, act_exp);
      @(posedge i_clk) i_srst <= 1;
      @(posedge i_clk) i_srst <= 0;
      act_exp = nxt;
      acc(0, 16'h0712, 16'h0000, 0);
      chk("persist", rdata, nxt[15:0]);
      repeat (60) begin
        @(posedge i_clk);
        for (int k = 0; k < 3; k++) e[k] = fx(act_exp[16*k +: 16], r, k);
        r <= 16'($random(seed));
        #1;
        chk("dout", dout, e);
      end
    end
    chk("active", act, act_exp);
    summarize();
  end
endmodule

// ### bench/sofs_checker.sv
`timescale 1ns/1ns
module sofs_checker #(
  parameter int NUM_OUT = 3
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_power_stage_en,
  input wire logic [NUM_OUT-1:0] i_user_level,
  input wire logic [15:0] o_rdata,
  input wire logic o_ack,
  input wire logic o_err,
  input wire logic [NUM_OUT-1:0] o_dout,
  input wire logic [NUM_OUT*16-1:0] o_active_sel
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  wire map = i_addr inside {16'h0712, 16'h0714, 16'h0716};
  wire ok = i_wdata inside {[16'h0001:16'h0003], [16'h0005:16'h0009], 16'h000D, 16'h000E,
    16'h0010};
  sequence s_wr0;
    i_wr && !i_power_stage_en && ok && i_addr == 16'h0712;
  endsequence
  sequence s_rd0;
    i_rd && i_addr == 16'h0712;
  endsequence
  AST_STAGE: assert property (i_wr && i_power_stage_en |=> o_err && !o_ack)
    else $error("write taken with stage on");
  AST_BADVAL: assert property (i_wr && !ok |=> o_err && !o_ack)
    else $error("undefined value taken");
  AST_ACCEPT: assert property (i_wr && map && ok && !i_power_stage_en |=> o_ack)
    else $error("valid write refused");
  AST_RDSTAGE: assert property (i_rd && !i_wr && map |=> o_ack && !o_err)
    else $error("read refused");
  AST_UNMAP: assert property ((i_wr || i_rd) && !map |=> o_err && !o_ack)
    else $error("unmapped access taken");
  AST_STORE: assert property (s_wr0 ##1 !i_wr ##1 s_rd0 |=> o_rdata == $past(i_wdata, 3))
    else $error("stored value lost");
  AST_HOLD: assert property (!i_srst |=> $stable(o_active_sel))
    else $error("active selector moved");
  AST_FREE: assert property (!i_srst && o_active_sel[15:0] == 16'h0001 |=>
    o_dout[0] == $past(i_user_level[0]))
    else $error("free output not user level");
endmodule
bind sofs_top sofs_checker #(.NUM_OUT(NUM_OUT)) u_chk (.*);

// ### bench/sofs_ctrl_model.sv
`timescale 1ns/1ns
module sofs_ctrl_model (
  input wire logic i_run,
  input wire logic i_cfg,
  output logic o_stage_en
);
  // stage dropped while reconfiguring
  assign o_stage_en = i_run && !i_cfg;
endmodule

// ### rtl/sofs_defs.svh
`ifndef SOFS_DEFS_SVH
`define SOFS_DEFS_SVH
`define SOFS_ADDR_OUT0 16'h0712
`define SOFS_ADDR_OUT1 16'h0714
`define SOFS_ADDR_OUT2 16'h0716
`define SOFS_ADDR_STEP 16'h0002
`define SOFS_FN_FREE 16'h0001
`define SOFS_FN_NOFAULT 16'h0002
`define SOFS_FN_ACTIVE 16'h0003
`define SOFS_FN_POSWIN 16'h0005
`define SOFS_FN_VELWIN 16'h0006
`define SOFS_FN_VELTHR 16'h0007
`define SOFS_FN_CURTHR 16'h0008
`define SOFS_FN_HALTACK 16'h0009
`define SOFS_FN_STILL 16'h000D
`define SOFS_FN_SELERR 16'h000E
`define SOFS_FN_SELWARN 16'h0010
`define SOFS_SEL_RESET 16'h0001
`endif

// ### rtl/sofs_output_mux.sv
`timescale 1ns/1ns
`include "sofs_defs.svh"
module sofs_output_mux
  import sofs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [15:0] i_sel,
  input wire logic i_user_level,
  sofs_status_if.dst st,
  output logic o_out
);
  logic out_d;
  always_comb begin
    out_d = 1'b0;
    case (i_sel)
      `SOFS_FN_FREE: out_d = i_user_level;
      `SOFS_FN_NOFAULT: out_d = (st.state == SOFS_ST_READY_TO_SWITCH_ON) ||
        (st.state == SOFS_ST_SWITCHED_ON) ||
        (st.state == SOFS_ST_OPERATION_ENABLE);
      `SOFS_FN_ACTIVE: out_d = (st.state == SOFS_ST_OPERATION_ENABLE);
      `SOFS_FN_POSWIN: out_d = st.pos_win &&
        ((st.mode == SOFS_MODE_JOG) || (st.mode == SOFS_MODE_GEAR));
      `SOFS_FN_VELWIN: out_d = st.vel_win && (st.mode != SOFS_MODE_TORQUE);
      `SOFS_FN_VELTHR: out_d = st.vel_below;
      `SOFS_FN_CURTHR: out_d = st.cur_below;
      `SOFS_FN_HALTACK: out_d = st.halt_ack;
      `SOFS_FN_STILL: out_d = st.standstill;
      `SOFS_FN_SELERR: out_d = st.sel_err;
      `SOFS_FN_SELWARN: out_d = st.sel_warn;
      default: out_d = 1'b0;
    endcase
  end
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_out <= 1'b0;
    end else begin
      o_out <= out_d;
    end
  end
endmodule

// ### rtl/sofs_pkg.sv
package sofs_pkg;
  typedef enum logic [1:0] {
    SOFS_MODE_JOG,
    SOFS_MODE_GEAR,
    SOFS_MODE_TORQUE,
    SOFS_MODE_VELOCITY
  } sofs_mode_type;
  typedef enum logic [2:0] {
    SOFS_ST_NOT_READY,
    SOFS_ST_SWITCH_ON_DISABLED,
    SOFS_ST_READY_TO_SWITCH_ON,
    SOFS_ST_SWITCHED_ON,
    SOFS_ST_OPERATION_ENABLE,
    SOFS_ST_QUICK_STOP,
    SOFS_ST_FAULT
  } sofs_state_type;
endpackage

// ### rtl/sofs_status_if.sv
`timescale 1ns/1ns
interface sofs_status_if;
  import sofs_pkg::*;
  sofs_state_type state;
  sofs_mode_type mode;
  logic pos_win;
  logic vel_win;
  logic vel_below;
  logic cur_below;
  logic halt_ack;
  logic standstill;
  logic sel_err;
  logic sel_warn;
  modport src (output state, mode, pos_win, vel_win, vel_below, cur_below, halt_ack,
    standstill, sel_err, sel_warn);
  modport dst (input state, mode, pos_win, vel_win, vel_below, cur_below, halt_ack,
    standstill, sel_err, sel_warn);
endinterface

// ### rtl/sofs_top.sv
`timescale 1ns/1ns
`include "sofs_defs.svh"
module sofs_top
  import sofs_pkg::*;
#(
  parameter int NUM_OUT = 3
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_wdata,
  output logic [15:0] o_rdata,
  output logic o_ack,
  output logic o_err,
  input wire logic i_power_stage_en,
  input wire logic [2:0] i_drive_state,
  input wire logic [1:0] i_mode,
  input wire logic i_pos_win,
  input wire logic i_vel_win,
  input wire logic i_vel_below,
  input wire logic i_cur_below,
  input wire logic i_halt_ack,
  input wire logic i_standstill,
  input wire logic i_sel_err,
  input wire logic i_sel_warn,
  input wire logic [NUM_OUT-1:0] i_user_level,
  output logic [NUM_OUT-1:0] o_dout,
  output logic [NUM_OUT*16-1:0] o_active_sel
);
  if (NUM_OUT < 1 || NUM_OUT > 3) begin : gen_bad_num_out
    $error("NUM_OUT must be 1 to 3");
  end

  function automatic logic sel_valid(input logic [15:0] v);
    case (v)
      `SOFS_FN_FREE, `SOFS_FN_NOFAULT, `SOFS_FN_ACTIVE, `SOFS_FN_POSWIN,
      `SOFS_FN_VELWIN, `SOFS_FN_VELTHR, `SOFS_FN_CURTHR, `SOFS_FN_HALTACK,
      `SOFS_FN_STILL, `SOFS_FN_SELERR, `SOFS_FN_SELWARN: sel_valid = 1'b1;
      default: sel_valid = 1'b0;
    endcase
  endfunction

  function automatic logic [15:0] out_addr(input int idx);
    out_addr = 16'(`SOFS_ADDR_OUT0 + idx * `SOFS_ADDR_STEP);
  endfunction

  logic [15:0] stored_q [NUM_OUT];
  logic [15:0] active_q [NUM_OUT];
  logic [NUM_OUT-1:0] hit;
  logic [15:0] rdata_d;
  logic any_hit;

  sofs_status_if st_if ();
  assign st_if.state = sofs_state_type'(i_drive_state);
  assign st_if.mode = sofs_mode_type'(i_mode);
  assign st_if.pos_win = i_pos_win;
  assign st_if.vel_win = i_vel_win;
  assign st_if.vel_below = i_vel_below;
  assign st_if.cur_below = i_cur_below;
  assign st_if.halt_ack = i_halt_ack;
  assign st_if.standstill = i_standstill;
  assign st_if.sel_err = i_sel_err;
  assign st_if.sel_warn = i_sel_warn;

  always_comb begin
    any_hit = 1'b0;
    rdata_d = 16'h0000;
    for (int k = 0; k < NUM_OUT; k++) begin
      if (hit[k]) begin
        any_hit = 1'b1;
        rdata_d = stored_q[k];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_OUT; g++) begin : gen_out
      assign hit[g] = (i_addr == out_addr(g));
      // persistent store survives reset; blank or corrupt content falls back to factory value
      always_ff @(posedge i_clk) begin
        if (i_srst) begin
          if (!sel_valid(stored_q[g])) begin
            stored_q[g] <= `SOFS_SEL_RESET;
          end
        end else if (i_wr && hit[g] && !i_power_stage_en && sel_valid(i_wdata)) begin
          stored_q[g] <= i_wdata;
        end
      end
      // reset models power-up: stored value becomes active
      always_ff @(posedge i_clk) begin
        if (i_srst) begin
          active_q[g] <= sel_valid(stored_q[g]) ? stored_q[g] : `SOFS_SEL_RESET;
        end
      end
      assign o_active_sel[g*16 +: 16] = active_q[g];
      sofs_output_mux u_mux (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_sel(active_q[g]),
        .i_user_level(i_user_level[g]),
        .st(st_if.dst),
        .o_out(o_dout[g])
      );
    end
  endgenerate

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_ack <= 1'b0;
      o_err <= 1'b0;
      o_rdata <= 16'h0000;
    end else begin
      o_ack <= (i_wr || i_rd) && any_hit &&
        !(i_wr && (i_power_stage_en || !sel_valid(i_wdata)));
      o_err <= (i_wr || i_rd) && !(any_hit &&
        !(i_wr && (i_power_stage_en || !sel_valid(i_wdata))));
      if (i_rd && any_hit) begin
        o_rdata <= rdata_d;
      end
    end
  end
endmodule
